// file: core/quick_test_sequencer.sv
// Purpose: button driven quick test sequencer with two digit display
// Assumes: inputs synchronous to clk_in except display_button_in
// Notes:   sensor resistances arrive already measured, in ohms
`timescale 1ns/100ps

// Functional notes
// (RULE_01) no start without closed timeclock contact
// (RULE_02) occupied entry: initialization, display 20
// (RULE_03) press in init: self-test, 88, lamp
// (RULE_04) no press in 2 min: start unit
// (RULE_05) 33 steps, two presses each
// (RULE_06) step number dotted, result undotted
// (RULE_07) 10 min without press: start unit
// (RULE_08) no stepping back; power cycle to repeat
// (RULE_09) config, sensor, then relay sections
// (RULE_10) steps 1,2,4 show 01, 2, 60
// (RULE_11) step 3 unloaders from switches 6,7
// (RULE_12) steps 5-8 show switches 2-5
// (RULE_13) step 9 shows enthalpy contact state
// (RULE_14) steps 10,11 show low-pressure switches
// (RULE_15) steps 12,13 always show 1
// (RULE_16) sensor steps: 1 valid, 0 fault
// (RULE_17) steps 14-17 supply, return, condenser sensors
// (RULE_18) steps 18-23 space sensor and pots
// (RULE_19) valid resistance 219 to 363000 ohms
// (RULE_20) config from fixed header plus switches
// (RULE_21) after init timeout display blank until press
// (RULE_22) compressor on 10 s, shows 0,1,0
// (RULE_23) button synchronised, debounced, counted per press
module quick_test_sequencer
	import qt_pkg::*;
#(
	parameter logic [39:0] INIT_CYCLES = INIT_CYCLES_DEF,
	parameter logic [39:0] IDLE_CYCLES = IDLE_CYCLES_DEF,
	parameter logic [39:0] COMP_CYCLES = COMP_CYCLES_DEF,
	parameter logic [39:0] DEB_CYCLES  = DEB_CYCLES_DEF
) (
	input  wire logic                               clk_in,
	input  wire logic                               rst_in,
	input  wire logic                               timeclock_in,
	input  wire logic                               display_button_in,
	input  wire switch_s                            switches_in,
	input  wire logic [SENSOR_COUNT-1:0][18:0]      sensor_ohms_in,
	output display_s                                display_out,
	output logic                                    alarm_lamp_out,
	output logic                                    self_test_out,
	output logic                                    unit_start_out,
	output logic [RELAY_COUNT-1:0]                  relay_out
);

	// ==========================================================
	// state
	typedef struct packed {
		logic                   sync1;
		logic                   sync2;
		logic                   btn_db;
		logic [39:0]            deb_cnt;
		qt_state_e              state;
		logic [5:0]             step;
		logic [39:0]            timer;
		logic                   comp_on;
		logic [39:0]            comp_cnt;
		display_s               disp;
		logic                   alarm;
		logic                   start;
		logic [RELAY_COUNT-1:0] relay;
	} qt_s;

	qt_s st_reg;
	qt_s st_next;
	logic press_w;
	logic in_test_w;
	logic [SENSOR_COUNT-1:0] valid_w;

	localparam display_s BLANK = '0;

	// ==========================================================
	// display helpers
	function automatic display_s show_code(input logic two, input logic [7:0] bcd);
		display_s d;
		d = '0;
		d.hi_on = two;
		d.hi_digit = two ? bcd[7:4] : 4'h0;
		d.lo_on = 1'b1;
		d.lo_digit = bcd[3:0];
		return d;
	endfunction

	function automatic display_s show_step(input logic [5:0] s);
		display_s d;
		logic [3:0] tens;
		tens = 4'(s / 6'd10);
		d = '0;
		d.hi_on = (tens != 4'h0);
		d.hi_digit = tens;
		d.hi_dp = (tens != 4'h0); // RULE_06
		d.lo_on = 1'b1;
		d.lo_digit = 4'(s % 6'd10);
		d.lo_dp = 1'b1; // RULE_06
		return d;
	endfunction

	// sensor order: supply, return, cond1, cond2, space/reset, then pots
	for (genvar i = 0; i < SENSOR_COUNT; i++) begin : g_valid
		assign valid_w[i] = (sensor_ohms_in[i] >= OHM_MIN) && (sensor_ohms_in[i] <= OHM_MAX); // RULE_19
	end

	assign in_test_w = (st_reg.state == S_READY) || (st_reg.state == S_NUMBER) ||
		(st_reg.state == S_RESULT);

	// ==========================================================
	// next state
	always_comb begin
		logic       two;
		logic [7:0] code;
		logic [3:0] ridx;
		logic [3:0] sidx;
		st_next = st_reg;
		press_w = 1'b0;
		two = 1'b0;
		code = 8'h00;
		ridx = 4'(st_reg.step - STEP_RELAY_0);
		sidx = 4'(st_reg.step - STEP_SENSOR_0);

		// button: two flops, then stable-count filter
		st_next.sync1 = display_button_in; // RULE_23
		st_next.sync2 = st_reg.sync1; // RULE_23
		if (st_reg.sync2 != st_reg.btn_db) begin
			if (st_reg.deb_cnt == DEB_CYCLES - 40'h00_0000_0001) begin
				st_next.btn_db = st_reg.sync2;
				st_next.deb_cnt = '0;
				press_w = st_reg.sync2; // RULE_23
			end else begin
				st_next.deb_cnt = st_reg.deb_cnt + 40'h00_0000_0001;
			end
		end else begin
			st_next.deb_cnt = '0;
		end

		// compressor run, display 0 then 1 then 0
		if (st_reg.comp_on) begin
			if (st_reg.comp_cnt == COMP_CYCLES - 40'h00_0000_0001) begin
				st_next.comp_on = 1'b0; // RULE_22
				st_next.relay[RLY_COMP1] = 1'b0;
				st_next.relay[RLY_COMP2] = 1'b0;
				st_next.disp = show_code(1'b0, 8'h00);
			end else begin
				st_next.comp_cnt = st_reg.comp_cnt + 40'h00_0000_0001;
				st_next.disp = show_code(1'b0, 8'h01); // RULE_22
			end
		end

		// result code of the current step
		case (st_reg.step)
			6'h01: begin
				two = 1'b1;
				code = CODE_UNIT_TYPE; // RULE_10 RULE_20
			end
			6'h02: code = CODE_COMPRESSORS; // RULE_10
			6'h03: code = (switches_in.option_sw[6:5] == UNLOAD_ONE_SW) ?
				CODE_UNLOAD_ONE : CODE_UNLOAD_TWO; // RULE_11
			6'h04: begin
				two = 1'b1;
				code = CODE_LINE_HZ; // RULE_10
			end
			6'h05, 6'h06, 6'h07, 6'h08: code = {7'h00,
				switches_in.option_sw[3'(st_reg.step - 6'h04)]}; // RULE_12
			6'h09: code = {7'h00, switches_in.enthalpy_contact}; // RULE_13
			6'h0A: code = {7'h00, switches_in.low_pressure[0]}; // RULE_14
			6'h0B: code = {7'h00, switches_in.low_pressure[1]}; // RULE_14
			6'h0C, 6'h0D: code = 8'h01; // RULE_15
			6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17:
				code = {7'h00, valid_w[sidx]}; // RULE_16 RULE_17 RULE_18
			6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C: code = 8'h01; // RULE_09
			default: code = 8'h00;
		endcase

		// ==========================================================
		// sequencer
		if (!timeclock_in) begin
			st_next.state = S_IDLE; // RULE_01
			st_next.disp = BLANK;
			st_next.alarm = 1'b0;
			st_next.start = 1'b0;
			st_next.relay = '0;
			st_next.comp_on = 1'b0;
			st_next.timer = '0;
			// a new self-test always starts from step 1
			st_next.step = '0;
		end else begin
			case (st_reg.state)
				S_IDLE: begin
					st_next.state = S_INIT; // RULE_02
					st_next.disp = show_code(1'b1, CODE_INIT); // RULE_02
					st_next.timer = '0;
				end
				S_INIT: begin
					if (press_w) begin
						st_next.state = S_READY; // RULE_03
						st_next.disp = show_code(1'b1, CODE_READY);
						st_next.alarm = 1'b1;
						st_next.timer = '0;
					end else if (st_reg.timer == INIT_CYCLES - 40'h00_0000_0001) begin
						st_next.state = S_RUN; // RULE_04
						st_next.start = 1'b1;
						st_next.disp = BLANK; // RULE_21
					end else begin
						st_next.timer = st_reg.timer + 40'h00_0000_0001;
					end
				end
				S_READY, S_NUMBER, S_RESULT: begin
					if (press_w && !st_reg.comp_on) begin
						st_next.timer = '0;
						case (st_reg.state)
							S_READY: begin
								st_next.state = S_NUMBER; // RULE_05
								st_next.step = STEP_FIRST;
								st_next.disp = show_step(STEP_FIRST);
							end
							S_NUMBER: begin
								st_next.state = S_RESULT; // RULE_05
								st_next.disp = show_code(two, code); // RULE_06
								if (st_reg.step >= STEP_RELAY_0) begin
									st_next.relay[ridx] = 1'b1; // RULE_09
								end
								if (st_reg.step == STEP_COMP1 || st_reg.step == STEP_COMP2) begin
									st_next.comp_on = 1'b1; // RULE_22
									st_next.comp_cnt = '0;
								end
							end
							default: begin
								st_next.relay = '0;
								// fan relay stays on for the rest of the test
								st_next.relay[RLY_FAN] = st_reg.relay[RLY_FAN];
								if (st_reg.step == STEP_LAST) begin
									st_next.state = S_RUN;
									st_next.start = 1'b1;
									st_next.alarm = 1'b0;
									st_next.relay = '0;
									st_next.disp = BLANK;
								end else begin
									st_next.state = S_NUMBER; // RULE_08
									st_next.step = st_reg.step + 6'h01;
									st_next.disp = show_step(st_reg.step + 6'h01);
								end
							end
						endcase
					end else if (st_reg.timer == IDLE_CYCLES - 40'h00_0000_0001) begin
						st_next.state = S_RUN; // RULE_07
						st_next.start = 1'b1;
						st_next.alarm = 1'b0;
						st_next.relay = '0;
						st_next.comp_on = 1'b0;
						st_next.disp = BLANK;
					end else begin
						st_next.timer = st_reg.timer + 40'h00_0000_0001;
					end
				end
				S_RUN: begin
					st_next.start = 1'b1; // RULE_01
					if (press_w) begin
						st_next.disp = show_code(1'b0, 8'h00); // RULE_21
					end
				end
				default: st_next.state = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign display_out = st_reg.disp;
	assign alarm_lamp_out = st_reg.alarm;
	assign self_test_out = (st_reg.state == S_READY) || (st_reg.state == S_NUMBER) ||
		(st_reg.state == S_RESULT);
	assign unit_start_out = st_reg.start;
	assign relay_out = st_reg.relay;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	a_start_gate: assert property (!timeclock_in |=> !unit_start_out && !self_test_out) // RULE_01
		else $error("unit start while contact open");

	a_init_code: assert property ( // RULE_02
		(st_reg.state == S_IDLE) && timeclock_in |=>
		display_out.hi_on && display_out.hi_digit == 4'h2 && display_out.lo_digit == 4'h0
		&& !display_out.lo_dp)
		else $error("initialization code not shown");

	a_ready_code: assert property ( // RULE_03
		(st_reg.state == S_INIT) && press_w && timeclock_in |=>
		alarm_lamp_out && self_test_out && display_out.hi_digit == 4'h8 &&
		display_out.lo_digit == 4'h8)
		else $error("self-test entry not shown");

	a_init_timeout: assert property ( // RULE_04
		(st_reg.state == S_INIT) && !press_w && timeclock_in &&
		st_reg.timer == INIT_CYCLES - 40'h00_0000_0001 |=>
		unit_start_out && !self_test_out && !display_out.lo_on)
		else $error("initialization timeout missed");

	a_two_press: assert property ( // RULE_05
		(st_reg.state == S_NUMBER) && press_w && !st_reg.comp_on &&
		timeclock_in |=> (st_reg.state == S_RESULT) && $stable(st_reg.step))
		else $error("second press did not run the step");

	a_step_dots: assert property ( // RULE_06
		(st_reg.state == S_NUMBER) |->
		display_out.lo_dp && (display_out.hi_dp == display_out.hi_on))
		else $error("step number dots wrong");

	a_result_dots: assert property ( // RULE_06
		(st_reg.state == S_RESULT) |->
		!display_out.lo_dp && !display_out.hi_dp)
		else $error("result code has dots");

	a_idle_timeout: assert property ( // RULE_07
		in_test_w && !press_w && timeclock_in &&
		st_reg.timer == IDLE_CYCLES - 40'h00_0000_0001 |=> unit_start_out && !alarm_lamp_out
		&& relay_out == '0)
		else $error("inactivity timeout missed");

	a_no_backstep: assert property ( // RULE_08
		in_test_w && $past(in_test_w) |->
		(st_reg.step == $past(st_reg.step)) ||
		(st_reg.step == $past(st_reg.step) + 6'h01))
		else $error("step moved backward");

	a_sensor_check: assert property ( // RULE_16
		(st_reg.state == S_NUMBER) && press_w && timeclock_in &&
		st_reg.step == STEP_SENSOR_0 |=> display_out.lo_digit == {3'h0, $past(valid_w[0])})
		else $error("supply sensor result wrong");

	// an open contact also stops the compressor, so only a closed one counts
	a_comp_time: assert property ( // RULE_22
		$fell(st_reg.comp_on) && $past(timeclock_in) |->
		$past(st_reg.comp_cnt) == COMP_CYCLES - 40'h00_0000_0001 &&
		relay_out[RLY_COMP1] == 1'b0 && relay_out[RLY_COMP2] == 1'b0)
		else $error("compressor run length wrong");

	a_press_edge: assert property (press_w |=> !press_w) // RULE_23
		else $error("press counted twice");

endmodule

// file: core/qt_pkg.sv
// Purpose: shared constants and types for the quick test sequencer
// Assumes: 100 MHz controller clock
// Notes:   times are kept in their own unit, cycle counts derived here
package qt_pkg;

	// ==========================================================
	// clock and times
	localparam logic [39:0] CLK_HZ           = 40'h00_05F5_E100;
	localparam logic [39:0] SEC_PER_MIN      = 40'h00_0000_003C;
	localparam logic [39:0] MS_PER_SEC       = 40'h00_0000_03E8;
	localparam logic [39:0] INIT_TIME_MIN    = 40'h00_0000_0002;
	localparam logic [39:0] IDLE_TIME_MIN    = 40'h00_0000_000A;
	localparam logic [39:0] COMP_RUN_SEC     = 40'h00_0000_000A;
	localparam logic [39:0] DEBOUNCE_MS      = 40'h00_0000_000A;
	localparam logic [39:0] INIT_CYCLES_DEF  = INIT_TIME_MIN * SEC_PER_MIN * CLK_HZ;
	localparam logic [39:0] IDLE_CYCLES_DEF  = IDLE_TIME_MIN * SEC_PER_MIN * CLK_HZ;
	localparam logic [39:0] COMP_CYCLES_DEF  = COMP_RUN_SEC * CLK_HZ;
	localparam logic [39:0] DEB_CYCLES_DEF   = DEBOUNCE_MS * CLK_HZ / MS_PER_SEC;

	// ==========================================================
	// steps and codes (codes are two bcd digits)
	localparam logic [5:0]  STEP_FIRST       = 6'h01;
	localparam logic [5:0]  STEP_LAST        = 6'h21;
	localparam logic [5:0]  STEP_SENSOR_0    = 6'h0E;
	localparam logic [5:0]  STEP_RELAY_0     = 6'h18;
	localparam logic [5:0]  STEP_FAN         = 6'h1A;
	localparam logic [5:0]  STEP_COMP1       = 6'h1D;
	localparam logic [5:0]  STEP_COMP2       = 6'h20;
	localparam logic [7:0]  CODE_INIT        = 8'h20;
	localparam logic [7:0]  CODE_READY       = 8'h88;
	localparam logic [7:0]  CODE_UNIT_TYPE   = 8'h01;
	localparam logic [7:0]  CODE_COMPRESSORS = 8'h02;
	localparam logic [7:0]  CODE_LINE_HZ     = 8'h60;
	localparam logic [7:0]  CODE_UNLOAD_TWO  = 8'h02;
	localparam logic [7:0]  CODE_UNLOAD_ONE  = 8'h01;
	localparam logic [1:0]  UNLOAD_ONE_SW    = 2'h3;
	localparam logic [18:0] OHM_MAX          = 19'h5_89F8;
	localparam logic [18:0] OHM_MIN          = 19'h0_00DB;
	localparam int          SENSOR_COUNT     = 10;
	localparam int          RELAY_COUNT      = 10;
	localparam int          RLY_FAN          = 2;
	localparam int          RLY_COMP1        = 5;
	localparam int          RLY_COMP2        = 8;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_INIT   = 3'b001,
		S_READY  = 3'b010,
		S_NUMBER = 3'b011,
		S_RESULT = 3'b100,
		S_RUN    = 3'b101
	} qt_state_e;

	typedef struct packed {
		logic       hi_on;
		logic [3:0] hi_digit;
		logic       hi_dp;
		logic       lo_on;
		logic [3:0] lo_digit;
		logic       lo_dp;
	} display_s;

	typedef struct packed {
		logic [7:0] option_sw;
		logic       enthalpy_contact;
		logic [1:0] low_pressure;
	} switch_s;

endpackage

// file: tb/service_tech.sv
// Purpose: service technician at the display pushbutton
// Assumes: press lengths well above the debounce filter
// Notes:   only clean presses and one short bounce are modelled
`timescale 1ns/100ps
module service_tech #(
	parameter int HOLD = 9
) (
	input  wire logic clk_in,
	output logic      button_out
);
	initial button_out = 1'b0;

	// ==========================================================
	// one whole press, held then released past the filter
	task automatic press();
		@(posedge clk_in);
		button_out <= 1'b1;
		repeat (HOLD) @(posedge clk_in);
		button_out <= 1'b0;
		repeat (HOLD) @(posedge clk_in);
		#1;
	endtask

	// single-cycle contact bounce
	task automatic glitch();
		@(posedge clk_in);
		button_out <= 1'b1;
		@(posedge clk_in);
		button_out <= 1'b0;
		repeat (HOLD) @(posedge clk_in);
		#1;
	endtask
endmodule

// file: tb/tb.sv
// Purpose: self-checking bench for the quick test sequencer
// Assumes: shortened timing parameters
// Notes:   two switch settings, one fixed sensor setting, boundary ohm values
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_errors++; \
	$display("wrong value %s exp %h got %h", nm, ex, gt); end end
module tb;
	import qt_pkg::*;
	localparam int INIT_N = 200;
	localparam int IDLE_N = 300;
	localparam int COMP_N = 20;
	localparam int DEB_N  = 3;
	logic                           clk_in;
	logic                           rst_in;
	logic                           timeclock_in;
	logic                           display_button_in;
	switch_s                        switches_in;
	logic [SENSOR_COUNT-1:0][18:0]  sensor_ohms_in;
	display_s                       display_out;
	logic                           alarm_lamp_out;
	logic                           self_test_out;
	logic                           unit_start_out;
	logic [RELAY_COUNT-1:0]         relay_out;
	int                             n_errors;
	int                             comparisons;

	quick_test_sequencer #(.INIT_CYCLES(40'(INIT_N)), .IDLE_CYCLES(40'(IDLE_N)),
		.COMP_CYCLES(40'(COMP_N)), .DEB_CYCLES(40'(DEB_N))) DUT (.clk_in(clk_in), .rst_in(rst_in),
		.timeclock_in(timeclock_in), .display_button_in(display_button_in),
		.switches_in(switches_in), .sensor_ohms_in(sensor_ohms_in),
		.display_out(display_out), .alarm_lamp_out(alarm_lamp_out),
		.self_test_out(self_test_out), .unit_start_out(unit_start_out),
		.relay_out(relay_out));
	service_tech #(.HOLD(DEB_N + 6)) tech (.clk_in(clk_in), .button_out(display_button_in));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// ==========================================================
	// helpers
	function automatic display_s show(logic [7:0] bcd, logic two, logic dot);
		show = {two, two ? bcd[7:4] : 4'h0, two & dot, 1'b1, bcd[3:0], dot};
	endfunction

	function automatic display_s step_no(int n);
		step_no = show({4'(n / 10), 4'(n % 10)}, n >= 10, 1'b1);
	endfunction

	function automatic logic [7:0] result(int s);
		logic [18:0] r;
		r = (s >= 14 && s <= 23) ? sensor_ohms_in[s - 14] : 19'h0_0000;
		case (s)
			1: result = 8'h01;
			2: result = 8'h02;
			3: result = 8'h01;
			4: result = 8'h60;
			5, 6, 7, 8: result = {7'h00, switches_in.option_sw[s - 4]};
			9: result = {7'h00, switches_in.enthalpy_contact};
			10, 11: result = {7'h00, switches_in.low_pressure[s - 10]};
			12, 13, 24, 25, 26, 27, 28: result = 8'h01;
			default: result = {7'h00, (s < 24) && r >= 19'd219 && r <= 19'd363000};
		endcase
	endfunction

	task automatic cyc(int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic power_up(logic tc);
		@(posedge clk_in);
		rst_in       <= 1'b1;
		timeclock_in <= 1'b0;
		repeat (16) @(posedge clk_in);
		rst_in       <= 1'b0;
		timeclock_in <= tc;
		cyc(3);
	endtask

	task automatic results();
		if (n_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic wait_start(int limit);
		for (int i = 0; i < limit && unit_start_out !== 1'b1; i++) cyc(1);
		`CHK("unit_start_out", 1'b1, unit_start_out)
		if (unit_start_out !== 1'b1) results();
	endtask

	// ==========================================================
	// scenarios
	task automatic t_no_contact();
		power_up(1'b0);
		tech.press();
		`CHK("display_out", 12'h000, display_out)
		`CHK("unit_start_out", 1'b0, unit_start_out)
		`CHK("self_test_out", 1'b0, self_test_out)
	endtask

	task automatic t_init_timeout();
		power_up(1'b1);
		`CHK("display_out", show(8'h20, 1'b1, 1'b0), display_out)
		tech.glitch();
		`CHK("display_out", show(8'h20, 1'b1, 1'b0), display_out)
		cyc(INIT_N - 40);
		`CHK("unit_start_out", 1'b0, unit_start_out)
		wait_start(60);
		`CHK("display_out", 12'h000, display_out)
		`CHK("self_test_out", 1'b0, self_test_out)
		tech.press();
		`CHK("display_out", show(8'h00, 1'b0, 1'b0), display_out)
	endtask

	task automatic t_idle_timeout();
		power_up(1'b1);
		// switches 6 and 7 not both closed: two unloaders
		@(posedge clk_in);
		switches_in.option_sw <= 8'h35;
		tech.press();
		for (int s = 1; s <= 3; s++) begin
			tech.press();
			tech.press();
		end
		`CHK("unloaders", show(8'h02, 1'b0, 1'b0), display_out)
		cyc(IDLE_N - 40);
		`CHK("self_test_out", 1'b1, self_test_out)
		wait_start(80);
		`CHK("self_test_out", 1'b0, self_test_out)
		@(posedge clk_in);
		switches_in.option_sw <= 8'h6A;
	endtask

	task automatic t_walk();
		power_up(1'b1);
		tech.press();
		`CHK("display_out", show(8'h88, 1'b1, 1'b0), display_out)
		`CHK("alarm_lamp_out", 1'b1, alarm_lamp_out)
		`CHK("self_test_out", 1'b1, self_test_out)
		for (int s = 1; s <= 33; s++) begin
			tech.press();
			`CHK("step number", step_no(s), display_out)
			tech.press();
			if (s == 29 || s == 32) begin
				`CHK("compressor run", show(8'h01, 1'b0, 1'b0), display_out)
				`CHK("compressor relay", 1'b1, relay_out[s - 24])
				cyc(COMP_N);
				`CHK("compressor relay", 1'b0, relay_out[s - 24])
			end else if (s >= 24) begin
				`CHK("relay_out", 1'b1, relay_out[s - 24])
			end
			`CHK("result", show(result(s), s == 1 || s == 4, 1'b0), display_out)
			if (s > 26) `CHK("fan relay", 1'b1, relay_out[2])
		end
		tech.press();
		`CHK("unit_start_out", 1'b1, unit_start_out)
		`CHK("self_test_out", 1'b0, self_test_out)
		`CHK("alarm_lamp_out", 1'b0, alarm_lamp_out)
		`CHK("relay_out", 10'h000, relay_out)
	endtask

	// ==========================================================
	// main sequence
	initial begin
		n_errors          = 0;
		comparisons       = 0;
		rst_in            = 1'b1;
		timeclock_in      = 1'b0;
		switches_in       = '{option_sw: 8'h6A, enthalpy_contact: 1'b1, low_pressure: 2'h2};
		sensor_ohms_in    = '{19'd362999, 19'd220, 19'd524287, 19'd100000, 19'd0,
			19'd5000, 19'd363001, 19'd363000, 19'd218, 19'd219};
		t_no_contact();
		t_init_timeout();
		t_idle_timeout();
		t_walk();
		results();
	end
endmodule
